//--- hdl/sscps_pkg.sv
// constants and types for the serial clock and port setup block
// What this block does
// - reset selects timing type 1
// - polarity and phase bits pick type
// - rate 000-110 divides clock, master mode
// - rate 111 means slave, external clock
// - clock select register resets to zero
// - direction bit 0 drives, 1 floats
// - both direction registers reset to ones
// - stopped mode frees pins, no transfers
// - enable low clears flag and shifter
package sscps_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] SSCPS_ADDR_PORT0_DIR = 16'hff20;
    localparam logic [15:0] SSCPS_ADDR_PORT1_DIR = 16'hff21;
    localparam logic [15:0] SSCPS_ADDR_MODE      = 16'hff88;
    localparam logic [15:0] SSCPS_ADDR_CLK_SEL   = 16'hff89;

    // reset values
    localparam logic [7:0] SSCPS_RST_PORT_DIR = 8'hff;
    localparam logic [7:0] SSCPS_RST_CLK_SEL  = 8'h00;
    localparam logic [7:0] SSCPS_RST_MODE     = 8'h00;

    // field positions
    localparam int SSCPS_MODE_ENABLE_POS = 7;
    localparam int SSCPS_MODE_ACTIVE_POS = 0;
    localparam int SSCPS_SEL_CKP_POS     = 4;
    localparam int SSCPS_SEL_DAP_POS     = 3;
    localparam int SSCPS_PORT0_FIXED_POS = 7;

    // pin positions on port 0
    localparam int SSCPS_PIN_SO  = 2;
    localparam int SSCPS_PIN_SI  = 3;
    localparam int SSCPS_PIN_SCK = 4;

    // rate code that selects the external clock
    localparam logic [2:0] SSCPS_RATE_SLAVE = 3'h7;
    // index of the last of the 16 edges in one byte
    localparam logic [3:0] SSCPS_LAST_EDGE  = 4'hf;

    // clock select fields travel together
    typedef struct packed {
        logic       ckp;
        logic       dap;
        logic [2:0] rate;
    } sscps_cfg_t;

    typedef enum logic [1:0] {
        SSCPS_IDLE  = 2'b01,
        SSCPS_SHIFT = 2'b10
    } sscps_state_t;
endpackage

//--- hdl/sscps_div.sv
// half-period tick generator for the master serial clock
`timescale 1ns/100ps
`default_nettype none
module sscps_div (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic [2:0] rate,
    output var  logic       tick_ff
);
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic       nxt_tick;
    logic [6:0] limit;

    // half period is 2^rate cycles, so full period is 2^(rate+1)
    always_comb begin
        limit    = 7'((8'h01 << rate) - 8'h01);
        nxt_cnt  = 7'h00;
        nxt_tick = 1'b0;
        if (run) begin
            if (cnt_ff == limit) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = 7'(cnt_ff + 7'h01);
            end
        end
    end

    // counter restarts whenever the shifter is idle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff  <= 7'h00;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end
endmodule // sscps_div
`default_nettype wire

//--- hdl/sscps_top.sv
// serial clock select, port direction and byte shifter
`timescale 1ns/100ps
`default_nettype none
module sscps_top
    import sscps_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_wdata,
    output var  logic [7:0]  cpu_rdata_ff,
    input  wire logic [7:0]  port0_latch,
    input  wire logic [7:0]  port1_latch,
    input  wire logic [7:0]  port0_in,
    input  wire logic [7:0]  port1_in,
    output var  logic [7:0]  port0_out_ff,
    output var  logic [7:0]  port0_oe_ff,
    output var  logic [7:0]  port1_out_ff,
    output var  logic [7:0]  port1_oe_ff,
    input  wire logic        tx_start,
    input  wire logic [7:0]  tx_data,
    output var  logic [7:0]  rx_data_ff,
    output var  logic        rx_done_ff
);
    import sscps_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0]   dir0_ff, dir1_ff, nxt_dir0, nxt_dir1;
    sscps_cfg_t   cfg_ff, nxt_cfg;
    logic         enable_ff, nxt_enable;
    logic [7:0]   nxt_rdata;
    logic [7:0]   sel_view;
    sscps_state_t state_ff, nxt_state;

    // register writes; clock select is frozen while enabled
    always_comb begin
        nxt_dir0   = dir0_ff;
        nxt_dir1   = dir1_ff;
        nxt_cfg    = cfg_ff;
        nxt_enable = enable_ff;
        if (cpu_wr) begin
            case (cpu_addr)
                SSCPS_ADDR_PORT0_DIR: nxt_dir0 = cpu_wdata;
                SSCPS_ADDR_PORT1_DIR: nxt_dir1 = cpu_wdata;
                SSCPS_ADDR_MODE:      nxt_enable = cpu_wdata[SSCPS_MODE_ENABLE_POS];
                SSCPS_ADDR_CLK_SEL: begin
                    if (!enable_ff) begin
                        nxt_cfg = sscps_cfg_t'(cpu_wdata[4:0]);
                    end
                end
                default: ;
            endcase
        end
        nxt_dir0[SSCPS_PORT0_FIXED_POS] = 1'b1;
    end

    assign sel_view = {3'h0, cfg_ff};

    // read mux, unmapped addresses read zero
    always_comb begin
        nxt_rdata = cpu_rdata_ff;
        if (cpu_rd) begin
            case (cpu_addr)
                SSCPS_ADDR_PORT0_DIR: nxt_rdata = dir0_ff;
                SSCPS_ADDR_PORT1_DIR: nxt_rdata = dir1_ff;
                SSCPS_ADDR_MODE:      nxt_rdata = {enable_ff, 6'h00, state_ff == SSCPS_SHIFT};
                SSCPS_ADDR_CLK_SEL:   nxt_rdata = sel_view;
                default:              nxt_rdata = 8'h00;
            endcase
        end
    end

    // register state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dir0_ff      <= SSCPS_RST_PORT_DIR;
            dir1_ff      <= SSCPS_RST_PORT_DIR;
            cfg_ff       <= sscps_cfg_t'(SSCPS_RST_CLK_SEL[4:0]);
            enable_ff    <= SSCPS_RST_MODE[SSCPS_MODE_ENABLE_POS];
            cpu_rdata_ff <= 8'h00;
        end else begin
            dir0_ff      <= nxt_dir0;
            dir1_ff      <= nxt_dir1;
            cfg_ff       <= nxt_cfg;
            enable_ff    <= nxt_enable;
            cpu_rdata_ff <= nxt_rdata;
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [7:0] p0_s1_ff, p0_s2_ff, p1_s1_ff, p1_s2_ff;
    logic       sck_prev_ff;

    // two stages before anything reads the pins; port 0 stages rest high like
    // the idle clock pin, so the edge detector sees no false edge after reset
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            p0_s1_ff    <= 8'hff;
            p0_s2_ff    <= 8'hff;
            p1_s1_ff    <= 8'h00;
            p1_s2_ff    <= 8'h00;
            sck_prev_ff <= 1'b1;
        end else begin
            p0_s1_ff    <= port0_in;
            p0_s2_ff    <= p0_s1_ff;
            p1_s1_ff    <= port1_in;
            p1_s2_ff    <= p1_s1_ff;
            sck_prev_ff <= p0_s2_ff[SSCPS_PIN_SCK];
        end
    end

    // ************************************************************
    // shifter
    // ************************************************************
    logic [7:0]   shreg_ff, nxt_shreg;
    logic [3:0]   edge_ff, nxt_edge;
    logic         so_ff, nxt_so;
    logic         sck_ff, nxt_sck;
    logic [7:0]   nxt_rx;
    logic         nxt_done;
    logic         is_slave;
    logic         tick;
    logic         ext_edge;
    logic         step;
    logic         leading;
    logic         sample;
    logic [7:0]   shifted;

    assign is_slave = (cfg_ff.rate == SSCPS_RATE_SLAVE);
    assign ext_edge = p0_s2_ff[SSCPS_PIN_SCK] ^ sck_prev_ff;

    sscps_div u_div (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .run     ((state_ff == SSCPS_SHIFT) && !is_slave),
        .rate    (cfg_ff.rate),
        .tick_ff (tick)
    );

    // each step is one clock edge; the first edge leaves the idle level
    always_comb begin
        nxt_state = state_ff;
        nxt_shreg = shreg_ff;
        nxt_edge  = edge_ff;
        nxt_so    = so_ff;
        nxt_sck   = sck_ff;
        nxt_rx    = rx_data_ff;
        nxt_done  = 1'b0;
        step      = is_slave ? ext_edge : tick;
        leading   = !edge_ff[0];
        sample    = leading ? cfg_ff.dap : !cfg_ff.dap;
        shifted   = {shreg_ff[6:0], p0_s2_ff[SSCPS_PIN_SI]};
        case (state_ff)
            SSCPS_IDLE: begin
                nxt_sck = !cfg_ff.ckp;
                if (enable_ff && tx_start) begin
                    nxt_state = SSCPS_SHIFT;
                    nxt_shreg = tx_data;
                    nxt_edge  = 4'h0;
                    if (cfg_ff.dap) begin
                        nxt_so = tx_data[7];
                    end
                end
            end
            SSCPS_SHIFT: begin
                if (step) begin
                    nxt_sck  = !sck_ff;
                    nxt_edge = 4'(edge_ff + 4'h1);
                    if (sample) begin
                        nxt_shreg = shifted;
                    end else begin
                        nxt_so = shreg_ff[7];
                    end
                    if (edge_ff == SSCPS_LAST_EDGE) begin
                        nxt_state = SSCPS_IDLE;
                        nxt_rx    = sample ? shifted : shreg_ff;
                        nxt_done  = 1'b1;
                    end
                end
            end
            default: nxt_state = SSCPS_IDLE;
        endcase
        // disabled: flag and shifter cleared at once
        if (!enable_ff) begin
            nxt_state = SSCPS_IDLE;
            nxt_shreg = 8'h00;
            nxt_edge  = 4'h0;
            nxt_so    = 1'b0;
            nxt_done  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= SSCPS_IDLE;
            shreg_ff   <= 8'h00;
            edge_ff    <= 4'h0;
            so_ff      <= 1'b0;
            sck_ff     <= 1'b1;
            rx_data_ff <= 8'h00;
            rx_done_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            shreg_ff   <= nxt_shreg;
            edge_ff    <= nxt_edge;
            so_ff      <= nxt_so;
            sck_ff     <= nxt_sck;
            rx_data_ff <= nxt_rx;
            rx_done_ff <= nxt_done;
        end
    end

    // ************************************************************
    // pin multiplexing
    // ************************************************************
    logic [7:0] nxt_p0_out;

    // serial owns its pins only while enabled; otherwise plain port
    always_comb begin
        nxt_p0_out = port0_latch;
        if (enable_ff) begin
            nxt_p0_out[SSCPS_PIN_SO] = so_ff & ~port0_latch[SSCPS_PIN_SO];
            if (!is_slave) begin
                nxt_p0_out[SSCPS_PIN_SCK] = sck_ff & port0_latch[SSCPS_PIN_SCK];
            end
        end
    end

    // direction bit 0 turns the output buffer on
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port0_out_ff <= 8'h00;
            port1_out_ff <= 8'h00;
            port0_oe_ff  <= 8'h00;
            port1_oe_ff  <= 8'h00;
        end else begin
            port0_out_ff <= nxt_p0_out;
            port1_out_ff <= port1_latch;
            port0_oe_ff  <= ~dir0_ff;
            port1_oe_ff  <= ~dir1_ff;
        end
    end
endmodule // sscps_top
`default_nettype wire

//--- verification/sscps_assertions.sv
// assertion checker for the serial clock and port setup block
`timescale 1ns/100ps
`default_nettype none
module sscps_chk
    import sscps_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata_ff,
    input wire logic [7:0]  port0_latch,
    input wire logic [7:0]  port0_out_ff,
    input wire logic [7:0]  port0_oe_ff,
    input wire logic [7:0]  port1_oe_ff,
    input wire logic        tx_start,
    input wire logic        rx_done_ff
);
    // ****
    // bus mirror
    // ****
    logic       en_ff;
    logic       nxt_en;
    logic [4:0] sel_ff;
    logic [4:0] nxt_sel;
    // select writes while enabled are dropped, as in the device
    always_comb begin
        nxt_en = en_ff;
        nxt_sel = sel_ff;
        if (cpu_wr && cpu_addr == SSCPS_ADDR_MODE) nxt_en = cpu_wdata[7];
        if (cpu_wr && cpu_addr == SSCPS_ADDR_CLK_SEL && !en_ff) nxt_sel = cpu_wdata[4:0];
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_ff <= 1'b0;
            sel_ff <= 5'h00;
        end else begin
            en_ff <= nxt_en;
            sel_ff <= nxt_sel;
        end
    end
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_dir1_alone;
        cpu_wr && cpu_addr == SSCPS_ADDR_PORT1_DIR ##1 !(cpu_wr && cpu_addr == SSCPS_ADDR_PORT1_DIR);
    endsequence
    // rate 0 byte that stays enabled through its first half
    sequence s_fast_byte;
        tx_start && en_ff && sel_ff[2:0] == 3'h0 ##1 (en_ff && !rx_done_ff)[*8];
    endsequence
    a_dir_reset: assert property ($rose(resetn) |-> port0_oe_ff == 8'h00 && port1_oe_ff == 8'h00)
        else $error("enable set after reset");
    a_oe_from_dir: assert property (s_dir1_alone |=> port1_oe_ff == ~$past(cpu_wdata, 2))
        else $error("enable not inverse of direction");
    a_fixed_input: assert property (port0_oe_ff[SSCPS_PORT0_FIXED_POS] == 1'b0)
        else $error("fixed input pin driven");
    a_byte_time: assert property (s_fast_byte |-> ##[7:15] rx_done_ff)
        else $error("rate 0 byte late");
    a_done_pulse: assert property (rx_done_ff |=> !rx_done_ff)
        else $error("done longer than one cycle");
    a_stop_quiet: assert property (rx_done_ff |-> $past(en_ff))
        else $error("transfer while stopped");
    a_stop_pins: assert property ($past(resetn) && !$past(en_ff) && !$past(en_ff, 2) && !$past(en_ff, 3)
        && $past(sel_ff) == 5'h00 |-> port0_out_ff == $past(port0_latch))
        else $error("pin not following latch");
    a_sel_read: assert property (cpu_rd && cpu_addr == SSCPS_ADDR_CLK_SEL
        |=> cpu_rdata_ff == {3'h0, $past(sel_ff)})
        else $error("select readback wrong");
    a_mode_read: assert property (cpu_rd && cpu_addr == SSCPS_ADDR_MODE |=> cpu_rdata_ff[7] == $past(en_ff))
        else $error("enable readback wrong");
endmodule // sscps_chk
bind sscps_top sscps_chk i_chk (
    .clk_sys(clk_sys), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata_ff(cpu_rdata_ff), .port0_latch(port0_latch), .port0_out_ff(port0_out_ff),
    .port0_oe_ff(port0_oe_ff), .port1_oe_ff(port1_oe_ff), .tx_start(tx_start), .rx_done_ff(rx_done_ff));
`default_nettype wire

//--- verification/sscps_peer.sv
// behavioural peripheral on the serial link
`timescale 1ns/100ps
`default_nettype none
module sscps_peer (
    input  wire logic        clk_sys,
    input  wire logic        sck_pin,
    input  wire logic        so_pin,
    input  wire logic        go,
    input  wire logic        si_lvl,
    output var  logic        si,
    output var  logic        sck_ext,
    output var  logic [15:0] so_bits,
    output var  int          edges
);
    // ****
    // link behaviour
    // ****
    initial edges = 0;
    initial so_bits = 16'h0000;
    initial sck_ext = 1'b1;
    // every toggle of the wire clock is counted and the data-out level kept;
    // sampling edges never move the data line, so the capture cannot race
    always @(sck_pin) begin
        edges++;
        so_bits = {so_bits[14:0], so_pin};
    end
    // data line is always driven here, so it never floats
    assign si = si_lvl;
    // slave byte: 16 edges, then the clock stands at its rest level
    always @(posedge go) begin
        repeat (16) begin
            repeat (8) @(posedge clk_sys);
            #3 sck_ext = ~sck_ext;
        end
    end
endmodule // sscps_peer
`default_nettype wire

//--- verification/tb_sync_serial_clock_port_setup.sv
// self-checking bench for the serial clock and port setup block
`timescale 1ns/100ps
`default_nettype none
module tb_sync_serial_clock_port_setup;
    import sscps_pkg::*;
    // ****
    // stimulus and pins
    // ****
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        cpu_wr = 1'b0;
    logic        cpu_rd = 1'b0;
    logic        tx_start = 1'b0;
    logic        go = 1'b0;
    logic        si_lvl = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [7:0]  latch0 = 8'h10;
    logic [7:0]  rdata, p0o, p0oe, p1o, p1oe, rxd;
    logic        done, sck_w, si_w, sck_ext;
    logic [15:0] so_bits;
    int          edges, n_fail = 0, comparisons = 0, n_done = 0;
    // released clock pin follows the partner's clock
    assign sck_w = p0oe[SSCPS_PIN_SCK] ? p0o[SSCPS_PIN_SCK] : sck_ext;
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) if (done === 1'b1) n_done++;
    sscps_top i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_wdata(cpu_wdata), .cpu_rdata_ff(rdata), .port0_latch(latch0), .port1_latch(8'h3c),
        .port0_in({3'h7, sck_w, si_w, 3'h7}), .port1_in(8'hff), .port0_out_ff(p0o), .port0_oe_ff(p0oe),
        .port1_out_ff(p1o), .port1_oe_ff(p1oe), .tx_start(tx_start), .tx_data(8'ha5),
        .rx_data_ff(rxd), .rx_done_ff(done));
    sscps_peer i_peer (.clk_sys(clk_sys), .sck_pin(sck_w), .so_pin(p0o[SSCPS_PIN_SO]), .go(go), .si_lvl(si_lvl),
        .si(si_w), .sck_ext(sck_ext), .so_bits(so_bits), .edges(edges));
    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // byte seen on the data-out pin: the level at every sampling edge of the last 16
    function automatic logic [7:0] so_byte(input logic [15:0] b, input logic dap);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 8; i++) v[7 - i] = b[15 - 2 * i - (dap ? 0 : 1)];
        return v;
    endfunction
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk_sys);
        cpu_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk_sys);
        cpu_rd = 1'b0;
        chk(rdata, e);
    endtask
    // one start pulse; with lim above 0 the bounded wait ends the run if no byte completes, with lim 0 it only waits 40 cycles
    task automatic pulse_wait(input int lim, output int n);
        int b0;
        b0 = n_done;
        n = 0;
        tx_start = 1'b1;
        @(negedge clk_sys);
        tx_start = 1'b0;
        if (lim == 0) repeat (40) @(negedge clk_sys);
        while (lim > 0 && n_done == b0) begin
            @(posedge clk_sys);
            n++;
            if (n > lim) begin
                n_fail++;
                close_out();
            end
        end
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        rd(SSCPS_ADDR_PORT0_DIR, 8'hff);
        rd(SSCPS_ADDR_PORT1_DIR, 8'hff);
        rd(SSCPS_ADDR_CLK_SEL, 8'h00);
        chk(p0oe, 8'h00);
        wr(SSCPS_ADDR_PORT0_DIR, 8'h00);
        rd(SSCPS_ADDR_PORT0_DIR, 8'h80);
        wr(SSCPS_ADDR_PORT1_DIR, 8'h0f);
        rd(SSCPS_ADDR_CLK_SEL, 8'h00);
        chk(p1oe, 8'hf0);
        wr(SSCPS_ADDR_CLK_SEL, 8'hff);
        rd(SSCPS_ADDR_CLK_SEL, 8'h1f);
    endtask
    task automatic t_master(input logic [7:0] sel, input logic si);
        int n;
        int e0;
        wr(SSCPS_ADDR_CLK_SEL, sel);
        wr(SSCPS_ADDR_PORT0_DIR, 8'heb);
        wr(SSCPS_ADDR_MODE, 8'h80);
        si_lvl = si;
        repeat (4) @(negedge clk_sys);
        chk(8'(sck_w), {7'h00, ~sel[SSCPS_SEL_CKP_POS]});
        e0 = edges;
        pulse_wait(2100, n);
        repeat (3) @(negedge clk_sys);
        chk(8'(edges - e0), 8'd16);
        chk(so_byte(so_bits, sel[SSCPS_SEL_DAP_POS]), 8'ha5);
        chk(8'(n >= (16 << sel[2:0]) && n <= (16 << sel[2:0]) + 8), 8'h01);
        chk(rxd, {8{si}});
        wr(SSCPS_ADDR_CLK_SEL, ~sel & 8'h1f);
        rd(SSCPS_ADDR_CLK_SEL, sel);
        wr(SSCPS_ADDR_MODE, 8'h00);
    endtask
    task automatic t_slave();
        int n;
        int b;
        wr(SSCPS_ADDR_CLK_SEL, 8'h07);
        wr(SSCPS_ADDR_PORT0_DIR, 8'hfb);
        wr(SSCPS_ADDR_MODE, 8'h80);
        si_lvl = 1'b1;
        b = n_done;
        pulse_wait(0, n);
        chk(8'(n_done - b), 8'h00);
        chk(8'(p0oe[SSCPS_PIN_SCK]), 8'h00);
        go = 1'b1;
        pulse_wait(300, n);
        chk(rxd, 8'hff);
        chk(so_byte(so_bits, 1'b0), 8'ha5);
        wr(SSCPS_ADDR_MODE, 8'h00);
    endtask
    task automatic t_abort();
        int n;
        wr(SSCPS_ADDR_CLK_SEL, 8'h02);
        wr(SSCPS_ADDR_PORT0_DIR, 8'heb);
        wr(SSCPS_ADDR_MODE, 8'h80);
        n = n_done;
        tx_start = 1'b1;
        repeat (20) @(negedge clk_sys);
        tx_start = 1'b0;
        rd(SSCPS_ADDR_MODE, 8'h81);
        wr(SSCPS_ADDR_MODE, 8'h00);
        rd(SSCPS_ADDR_MODE, 8'h00);
        wr(SSCPS_ADDR_CLK_SEL, 8'h00);
        latch0 = 8'h5a;
        repeat (100) @(negedge clk_sys);
        chk(8'(n_done - n), 8'h00);
        chk(p0o, 8'h5a);
        chk(p1o, 8'h3c);
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        t_reset();
        for (int t = 0; t < 4; t++) t_master(8'(t << 3), t[0]);
        for (int r = 1; r < 3; r++) t_master(8'(r), 1'b0);
        t_slave();
        t_abort();
        close_out();
    end
endmodule // tb_sync_serial_clock_port_setup
`default_nettype wire
